/* period_match_timer8.sv */
// Top of the 8-bit period match timer with its Avalon-MM register slave and interrupt.
`timescale 1ns/100ps
`default_nettype none

`include "timer2_consts.svh"

module period_match_timer8 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic period_match
);

    timer2_pkg::timer2_state_s st; // Registered state.
    timer2_pkg::timer2_state_s next_st; // Next state.
    logic pre_tick; // One-cycle increment pulse from the prescaler.
    logic post_done; // One-cycle pulse when the postscaler completes.
    logic access; // A request is completed at this edge.
    logic wr_low; // A completed write that carries the low byte.
    logic wr_count; // Software writes the counter.
    logic wr_control; // Software writes the control register.
    logic scaler_clear; // Clears the prescaler and postscaler.
    logic match_now; // Counter equals period in this cycle.
    logic roll; // Counter rolls to zero at this edge.
    logic [7:0] ctrl_byte; // Control register as software sees it.

    // Control register image, with bit 7 reading as zero.
    function automatic logic [7:0] ctrl_image(input timer2_pkg::timer2_ctrl_s c);
        ctrl_image = `T2_ZERO8;
        ctrl_image[`T2_CTRL_PRESCALE_HI:`T2_CTRL_PRESCALE_LO] = c.prescale_select;
        ctrl_image[`T2_CTRL_RUN_BIT] = c.timer2_run;
        ctrl_image[`T2_CTRL_POSTSCALE_HI:`T2_CTRL_POSTSCALE_LO] = c.postscale_select;
    endfunction

    // Places a one-bit flag at its position in a zero word.
    function automatic logic [31:0] flag_word(input logic bit_value);
        flag_word = `T2_ZERO32;
        flag_word[`T2_FLAG_BIT] = bit_value;
    endfunction

    // Turns the prescaler output into increments of the counter.
    timer2_prescaler u_prescaler (
        .mclk(mclk),
        .rst(rst),
        .clear(scaler_clear),
        .ctrl(st.ctrl),
        .tick(pre_tick)
    );

    // Divides counter matches down to the flag event.
    timer2_postscaler u_postscaler (
        .mclk(mclk),
        .rst(rst),
        .clear(scaler_clear),
        .advance(roll),
        .ctrl(st.ctrl),
        .done(post_done)
    );

    // Decodes completed bus accesses that steer the scalers.
    always_comb begin
        access = !st.waitrequest && (read || write);
        wr_low = access && write && byteenable[0];
        wr_count = wr_low && (address == `T2_ADDR_COUNT);
        wr_control = wr_low && (address == `T2_ADDR_CONTROL);
        scaler_clear = wr_count || wr_control; // see [R10]
        match_now = (st.timer2_count == st.timer2_period); // see [R3]
        roll = pre_tick && match_now && st.ctrl.timer2_run; // see [R4] [R5]
        ctrl_byte = ctrl_image(st.ctrl);
    end

    // Next state: counter, registers, flag, interrupt and bus answer.
    always_comb begin
        next_st = st;
        // The counter moves only on prescaler output while running; otherwise it holds.
        if (pre_tick && st.ctrl.timer2_run) begin // see [R9] [R13]
            if (match_now) begin
                next_st.timer2_count = `T2_ZERO8; // see [R4]
            end else begin
                next_st.timer2_count = st.timer2_count + `T2_ONE8; // see [R4]
            end
        end
        // Software writes land at the edge where waitrequest is sampled low.
        if (wr_low) begin
            if (address == `T2_ADDR_COUNT) begin
                next_st.timer2_count = writedata[7:0]; // see [R8]
            end else if (address == `T2_ADDR_PERIOD) begin
                next_st.timer2_period = writedata[7:0]; // see [R8]
            end else if (address == `T2_ADDR_CONTROL) begin
                // Only the control fields change; the counter keeps its value.
                next_st.ctrl.prescale_select = writedata[`T2_CTRL_PRESCALE_HI:`T2_CTRL_PRESCALE_LO]; // see [R2]
                next_st.ctrl.timer2_run = writedata[`T2_CTRL_RUN_BIT]; // see [R9] [R11]
                next_st.ctrl.postscale_select = writedata[`T2_CTRL_POSTSCALE_HI:`T2_CTRL_POSTSCALE_LO]; // see [R6]
            end else if (address == `T2_ADDR_FLAG_CLEAR) begin
                if (writedata[`T2_FLAG_BIT]) begin
                    next_st.period_match_flag = 1'b0; // see [R13]
                end
            end else if (address == `T2_ADDR_FLAG_ENABLE) begin
                next_st.flag_enable = writedata[`T2_FLAG_BIT];
            end
        end
        // The postscaler event is placed after the clear so that a coinciding set wins.
        if (post_done) begin
            next_st.period_match_flag = 1'b1; // see [R7]
        end
        // Interrupt level follows the enabled flag, from a flip-flop.
        next_st.irq = next_st.period_match_flag && next_st.flag_enable;
        // Exported match level, registered from the next counter and period.
        next_st.period_match = (next_st.timer2_count == next_st.timer2_period); // see [R12] [R3]
        // Waitrequest drops for one cycle, one cycle after a request appears.
        if (st.waitrequest && (read || write)) begin
            next_st.waitrequest = 1'b0;
        end else begin
            next_st.waitrequest = 1'b1;
        end
        // Read data are loaded as waitrequest drops; unmapped addresses read zero.
        if (st.waitrequest && read) begin
            if (address == `T2_ADDR_COUNT) begin
                next_st.readdata = {24'h00_0000, st.timer2_count}; // see [R8]
            end else if (address == `T2_ADDR_PERIOD) begin
                next_st.readdata = {24'h00_0000, st.timer2_period}; // see [R8]
            end else if (address == `T2_ADDR_CONTROL) begin
                next_st.readdata = {24'h00_0000, ctrl_byte};
            end else if (address == `T2_ADDR_FLAGS) begin
                next_st.readdata = flag_word(st.period_match_flag);
            end else if (address == `T2_ADDR_FLAG_ENABLE) begin
                next_st.readdata = flag_word(st.flag_enable);
            end else begin
                next_st.readdata = `T2_ZERO32;
            end
        end
    end

    // Registers the whole state; every reset returns the documented values.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st.timer2_count <= `T2_COUNT_RESET; // see [R8]
            st.timer2_period <= `T2_PERIOD_RESET; // see [R8]
            st.ctrl <= 7'(`T2_CONTROL_RESET); // The control state holds only the seven implemented bits.
            st.period_match_flag <= 1'b0;
            st.flag_enable <= 1'b0;
            st.waitrequest <= 1'b1;
            st.readdata <= `T2_ZERO32;
            st.irq <= 1'b0;
            st.period_match <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from flip-flops.
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign irq = st.irq;
    assign period_match = st.period_match;

endmodule

`default_nettype wire

/* timer2_consts.svh */
// Register offsets, field positions, reset values and counts of the period match timer.
// Function
// [R1] Instruction clock is mclk divided by four.
// [R2] Prescale select: 00 one, 01 four, 1x sixteen.
// [R3] Counter compared with period register every cycle.
// [R4] Counter counts up, loads zero after match.
// [R5] Each match advances the postscaler by one.
// [R6] Postscale field bits 6..3 selects 1:(n+1).
// [R7] Postscaler completion sets the period match flag.
// [R8] Counter, period read/write; reset 00h and FFh.
// [R9] Timer runs only while run bit 2 set.
// [R10] Count write, control write, reset clear scalers.
// [R11] Control write leaves counter value unchanged.
// [R12] Match signal exported for the companion timer gate.
// [R13] Timer off holds state; flag stays until cleared.
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// Byte addresses of the registers on the Avalon-MM slave.
`define T2_ADDR_COUNT 8'h00
`define T2_ADDR_PERIOD 8'h04
`define T2_ADDR_CONTROL 8'h08
`define T2_ADDR_FLAGS 8'h0C
`define T2_ADDR_FLAG_CLEAR 8'h10
`define T2_ADDR_FLAG_ENABLE 8'h14

// Reset values.
`define T2_COUNT_RESET 8'h00
`define T2_PERIOD_RESET 8'hFF
`define T2_CONTROL_RESET 8'h00
`define T2_ZERO8 8'h00
`define T2_ZERO32 32'h0000_0000

// Control register field positions.
`define T2_CTRL_PRESCALE_LO 0
`define T2_CTRL_PRESCALE_HI 1
`define T2_CTRL_RUN_BIT 2
`define T2_CTRL_POSTSCALE_LO 3
`define T2_CTRL_POSTSCALE_HI 6

// Position of the period match flag in the flag, clear and enable registers.
`define T2_FLAG_BIT 1

// Terminal count of the divide by four that makes the instruction clock.
`define T2_INST_DIV_LAST 2'h3

// Prescale codes and terminal counts of the prescaler.
`define T2_PRE_CODE_DIV1 2'h0
`define T2_PRE_CODE_DIV4 2'h1
`define T2_PRE_LAST_DIV1 4'h0
`define T2_PRE_LAST_DIV4 4'h3
`define T2_PRE_LAST_DIV16 4'hF

// Steps and zero values of the small counters.
`define T2_ONE8 8'h01
`define T2_ONE4 4'h1
`define T2_ONE2 2'h1
`define T2_ZERO4 4'h0
`define T2_ZERO2 2'h0

`endif

/* timer2_pkg.sv */
// Types shared by the period match timer and its scaler modules.
package timer2_pkg;

    // Control fields that steer the scalers and the counter.
    typedef struct packed {
        logic [3:0] postscale_select;
        logic timer2_run;
        logic [1:0] prescale_select;
    } timer2_ctrl_s;

    // State of the prescaler module.
    typedef struct packed {
        logic [1:0] inst_phase;
        logic [3:0] pre_count;
        logic tick;
    } prescale_state_s;

    // State of the postscaler module.
    typedef struct packed {
        logic [3:0] post_count;
        logic done;
    } postscale_state_s;

    // State of the top module.
    typedef struct packed {
        logic [7:0] timer2_count;
        logic [7:0] timer2_period;
        timer2_ctrl_s ctrl;
        logic period_match_flag;
        logic flag_enable;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
        logic period_match;
    } timer2_state_s;

endpackage

/* timer2_prescaler.sv */
// Instruction clock divider and selectable prescaler of the period match timer.
`timescale 1ns/100ps
`default_nettype none

`include "timer2_consts.svh"

module timer2_prescaler (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear,
    input var timer2_pkg::timer2_ctrl_s ctrl,
    output logic tick
);

    // Terminal count of the prescaler for a select code.
    function automatic logic [3:0] pre_last(input logic [1:0] code);
        if (code == `T2_PRE_CODE_DIV1) begin
            pre_last = `T2_PRE_LAST_DIV1; // see [R2]
        end else if (code == `T2_PRE_CODE_DIV4) begin
            pre_last = `T2_PRE_LAST_DIV4; // see [R2]
        end else begin
            pre_last = `T2_PRE_LAST_DIV16; // see [R2]
        end
    endfunction

    timer2_pkg::prescale_state_s st; // Registered state.
    timer2_pkg::prescale_state_s next_st; // Next state.
    logic inst_edge; // One mclk cycle in four marks an instruction clock.

    // The instruction clock phase runs free; the prescaler advances on it while the timer runs.
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        inst_edge = (st.inst_phase == `T2_INST_DIV_LAST); // see [R1]
        next_st.inst_phase = st.inst_phase + `T2_ONE2; // see [R1]
        if (clear) begin
            next_st.pre_count = `T2_ZERO4; // see [R10]
        end else if (ctrl.timer2_run && inst_edge) begin // see [R9]
            if (st.pre_count >= pre_last(ctrl.prescale_select)) begin
                next_st.pre_count = `T2_ZERO4;
                next_st.tick = 1'b1; // see [R1]
            end else begin
                next_st.pre_count = st.pre_count + `T2_ONE4;
            end
        end
    end

    // Registers the prescaler state.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0; // see [R10]
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick; // Comes straight from a flip-flop.

endmodule

`default_nettype wire

/* timer2_postscaler.sv */
// Match postscaler of the period match timer.
`timescale 1ns/100ps
`default_nettype none

`include "timer2_consts.svh"

module timer2_postscaler (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear,
    input wire logic advance,
    input var timer2_pkg::timer2_ctrl_s ctrl,
    output logic done
);

    timer2_pkg::postscale_state_s st; // Registered state.
    timer2_pkg::postscale_state_s next_st; // Next state.

    // Counts matches and pulses done after postscale_select plus one of them.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (clear) begin
            next_st.post_count = `T2_ZERO4; // see [R10]
        end else if (advance) begin // see [R5]
            if (st.post_count >= ctrl.postscale_select) begin // see [R6]
                next_st.post_count = `T2_ZERO4;
                next_st.done = 1'b1; // see [R7]
            end else begin
                next_st.post_count = st.post_count + `T2_ONE4; // see [R5]
            end
        end
    end

    // Registers the postscaler state.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0; // see [R10]
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done; // Comes straight from a flip-flop.

endmodule

`default_nettype wire

/* period_match_timer8_asserts.sv */
// Concurrent checks on the bus, interrupt and match ports of the period match timer.
`timescale 1ns/100ps
`default_nettype none

module period_match_timer8_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq,
    input wire logic period_match
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // High when the address names one of the six registers.
    wire logic mapped = address inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    // A request that the slave has just taken.
    sequence req_taken;
        (read || write) && waitrequest;
    endsequence
    // One answer cycle, then busy again.
    sequence one_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    chk_wait_answer: assert property (req_taken |=> one_answer)
        else $error("request not answered after exactly one wait cycle");
    chk_idle_busy: assert property (!(read || write) |=> waitrequest)
        else $error("waitrequest low without a request");
    chk_unmapped_zero: assert property (read && waitrequest && !mapped |=> readdata == 32'h0)
        else $error("unmapped read did not return zero");
    chk_clear_reads_zero: assert property (read && waitrequest && address == 8'h10 |=> readdata == 32'h0)
        else $error("flag clear register read not zero");
    chk_reserved_bits: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0 &&
        !(address == 8'h08 && readdata[7]))
        else $error("reserved read data bits not zero");
    chk_readdata_hold: assert property (!(read && !waitrequest) |-> $stable(readdata))
        else $error("readdata changed outside a read answer");
    chk_mask_irq: assert property (write && !waitrequest && address == 8'h14 && byteenable[0] &&
        !writedata[1] |-> ##[1:2] !irq)
        else $error("irq still high after masking");
    chk_match_reset: assert property ($fell(rst) |-> !period_match [*2])
        else $error("match high right after reset");
endmodule

bind period_match_timer8 period_match_timer8_asserts chk (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .period_match(period_match));
`default_nettype wire

/* tb.sv */
// Self-checking bench of the 8-bit period match timer.
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic WR = 1'b0;
    localparam logic RD = 1'b1;
    logic mclk, rst, read, write, waitrequest, irq, period_match;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    // Counters, seed and the bench's model of the timer settings.
    integer failures, n_tests, seed, per, pre, post, m_count, t0, i;

    // Device under test.
    period_match_timer8 dut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .period_match(period_match));

    // Free running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compares one result and counts it.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low.
    task automatic bus(input logic rdn, input logic [7:0] a, input logic [31:0] d);
        integer k;
        k = 0;
        @(posedge mclk);
        read <= rdn;
        write <= !rdn;
        address <= a;
        writedata <= d;
        do begin
            @(posedge mclk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            failures++;
            $display("unexpected at %0t: bus request not answered", $time);
        end
    endtask

    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(RD, a, 32'h0);
        check(rd, exp);
    endtask

    // Clears the flag, lets irq fall, then waits for the next raise.
    task automatic next_flag();
        integer k;
        k = 0;
        bus(WR, 8'h10, 32'h2);
        repeat (3) @(posedge mclk);
        while (irq !== 1'b1 && k < 40000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 40000) begin
            failures++;
            $display("unexpected at %0t: flag did not rise again", $time);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        $display("unexpected at %0t: run did not finish in time", $time);
        conclude();
    end

    // Main sequence of tests.
    initial begin
        seed = 32'h27CD665E;
        failures = 0;
        n_tests = 0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'hFF);
        rchk(8'h08, 32'h0);
        rchk(8'h20, 32'h0);
        rchk(8'h10, 32'h0);
        $display("test reset_values done");
        per = $unsigned($random(seed)) % 256;
        bus(WR, 8'h04, 32'(per));
        byteenable <= 4'hE;
        bus(WR, 8'h04, 32'h11);
        byteenable <= 4'hF;
        rchk(8'h04, 32'(per));
        bus(WR, 8'h08, 32'hF8);
        rchk(8'h08, 32'h78);
        bus(WR, 8'h00, 32'h5A);
        rchk(8'h00, 32'h5A);
        $display("test register_access done");
        // Flag period for every prescale code with random postscale and period, then prescale code 0 with postscale 15.
        bus(WR, 8'h14, 32'h2);
        for (i = 0; i < 5; i++) begin
            pre = (i < 4) ? i : 0;
            post = (i < 4) ? $unsigned($random(seed)) % 4 : 15;
            per = 3 + $unsigned($random(seed)) % 8;
            bus(WR, 8'h08, 32'h0);
            bus(WR, 8'h00, 32'h0);
            bus(WR, 8'h04, 32'(per));
            bus(WR, 8'h08, 32'(post * 8 + 4 + pre));
            next_flag();
            t0 = $time;
            next_flag();
            check(32'(($time - t0) / 20), 32'(4 * (pre == 0 ? 1 : pre == 1 ? 4 : 16) * (per + 1) * (post + 1)));
        end
        $display("test flag_period done");
        // Masked flag stays sticky, flag register ignores writes, stopped timer holds.
        bus(WR, 8'h14, 32'h0);
        bus(WR, 8'h10, 32'h2);
        repeat (800) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        bus(WR, 8'h0C, 32'h0);
        rchk(8'h0C, 32'h2);
        bus(WR, 8'h08, 32'h0);
        bus(RD, 8'h00, 32'h0);
        m_count = rd;
        repeat (100) @(posedge mclk);
        rchk(8'h00, 32'(m_count));
        // A nonzero count shows that a control write leaves the counter alone.
        bus(WR, 8'h00, 32'hA5);
        bus(WR, 8'h08, 32'h78);
        rchk(8'h00, 32'hA5);
        bus(WR, 8'h14, 32'h2);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        bus(WR, 8'h10, 32'h2);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        rchk(8'h0C, 32'h0);
        $display("test mask_and_hold done");
        // Control rewrites closer together than one divide by 16 step keep the counter at zero.
        bus(WR, 8'h00, 32'h0);
        for (i = 0; i < 8; i++) begin
            bus(WR, 8'h08, 32'h06);
            repeat (40) @(posedge mclk);
        end
        rchk(8'h00, 32'h0);
        $display("test scaler_clear done");
        // The exported match level follows counter equal to period while the timer is stopped.
        per = $unsigned($random(seed)) % 256;
        bus(WR, 8'h08, 32'h0);
        bus(WR, 8'h00, 32'(per));
        bus(WR, 8'h04, 32'(per));
        repeat (2) @(posedge mclk);
        check({31'h0, period_match}, 32'h1);
        bus(WR, 8'h04, 32'((per + 1) % 256));
        repeat (2) @(posedge mclk);
        check({31'h0, period_match}, 32'h0);
        $display("test match_output done");
        // A second reset in mid-run restores the counter, period, control and enable.
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'hFF);
        rchk(8'h08, 32'h0);
        rchk(8'h14, 32'h0);
        $display("test second_reset done");
        conclude();
    end
endmodule
`default_nettype wire
